// ---- pcmp_regs.svh ----
`ifndef PCMP_REGS_SVH
`define PCMP_REGS_SVH
// Register byte offsets
`define PCMP_A_CFG 8'h00
`define PCMP_A_STAT 8'h04
`define PCMP_A_VAL0 8'h08
`define PCMP_A_VAL1 8'h0c
`define PCMP_A_INC 8'h10
`define PCMP_A_PER 8'h14
`define PCMP_A_MASK 8'h18
`define PCMP_A_XPOS 8'h1c
`define PCMP_A_XVEL 8'h20
`define PCMP_A_POS 8'h24
// Configuration fields
`define PCMP_CFG_EN 0
`define PCMP_CFG_INV 1
`define PCMP_CFG_TOG 2
`define PCMP_CFG_MLO 3
`define PCMP_CFG_MHI 4
`define PCMP_CFG_SRC 16
`define PCMP_CFG_WMASK 32'h0001_001f
`define PCMP_CFG_RST 32'h0000_0000
// Status fields
`define PCMP_ST_LVL 0
`define PCMP_ST_M0 1
`define PCMP_ST_M1 2
// Pulse period width and timing
`define PCMP_PER_W 20
`define PCMP_CLK_NS 10
`define PCMP_PER_UNIT_NS 10
`define PCMP_LOOP_US 250
`define PCMP_LOOP_CYC (`PCMP_LOOP_US * 1000 / `PCMP_CLK_NS)
`define PCMP_VEL_FRAC 16
`endif

// ---- pcmp_pkg.sv ----
`default_nettype none
package pcmp_pkg;
	typedef enum logic [1:0] {
		PCMP_DUAL = 2'h0,
		PCMP_SGL = 2'h1,
		PCMP_WIN = 2'h2,
		PCMP_SGLE = 2'h3
	} pcmp_mode_t;

	typedef struct packed {
		logic a1, b1, a2, b2, ap, bp;
		logic [31:0] cnt;
	} pcmp_qst_t;

	typedef struct packed {
		logic [47:0] acc;
		logic [31:0] vel;
		logic [31:0] cnt;
	} pcmp_xst_t;

	typedef struct packed {
		logic [31:0] cfg, v0, v1, inc, prev, xpos, xvel, rdata;
		logic [19:0] per, pcnt;
		logic [1:0] mask, flg;
		logic lvl, pin, irq, xload;
	} pcmp_st_t;
endpackage
`default_nettype wire

// ---- pcmp_quad.sv ----
`default_nettype none
module pcmp_quad
	import pcmp_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic enc_a,
	input wire logic enc_b,
	output logic [31:0] count
);
	pcmp_qst_t s, n;

	// Two-flop sync, then x4 decode on the second stage only
	always_comb
	begin
		n = s;
		n.a1 = enc_a;
		n.b1 = enc_b;
		n.a2 = s.a1;
		n.b2 = s.b1;
		n.ap = s.a2;
		n.bp = s.b2;
		// A double change is a glitch: no step at all
		if ((s.a2 ^ s.ap) != (s.b2 ^ s.bp))
		begin
			if (s.a2 ^ s.bp)
				n.cnt = s.cnt + 32'h1;
			else
				n.cnt = s.cnt - 32'h1;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	assign count = s.cnt;
endmodule
`default_nettype wire

// ---- pcmp_extrap.sv ----
`include "pcmp_regs.svh"
`default_nettype none
module pcmp_extrap
	import pcmp_pkg::*;
#(
	parameter int LOOP_CYC = `PCMP_LOOP_CYC
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic load,
	input wire logic [31:0] pos_in,
	input wire logic [31:0] vel_in,
	output logic [31:0] pos
);
	pcmp_xst_t s, n;

	// Velocity is counts per clock with a binary fraction
	always_comb
	begin
		n = s;
		if (load)
		begin
			n.acc = {pos_in, 16'h0000};
			n.vel = vel_in;
			n.cnt = 32'h0;
		end
		else if (s.cnt < 32'(LOOP_CYC))
		begin
			// Stop after one loop period rather than run away
			n.acc = s.acc + {{16{s.vel[31]}}, s.vel};
			n.cnt = s.cnt + 32'h1;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	assign pos = s.acc[47:`PCMP_VEL_FRAC];
endmodule
`default_nettype wire

// ---- pcmp_top.sv ----
// Functional notes
// - Dual mode watches both compare values
// - Upward crossing adds increment to other value
// - Downward crossing subtracts increment from other value
// - Each crossing pulses or toggles the output
// - Zero increment keeps dual values fixed
// - Single mode: value 0 only, then add increment
// - Single mode fires in one direction only
// - Window: above value 0, up to value 1
// - Mode 3 disables itself past value 1
// - Quadrature source uses live count directly
// - Other sources use extrapolated loop position
// - Config: enable bit 0, mode bits 3-4
// - Pulse width 20-bit count of 10 ns
// - Status: live level, write-one-clear match flags
// - Config bit inverts output level
`include "pcmp_regs.svh"
`default_nettype none
module pcmp_top
	import pcmp_pkg::*;
#(
	parameter int LOOP_CYC = `PCMP_LOOP_CYC
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic enc_a,
	input wire logic enc_b,
	output logic cmp_out,
	output logic irq
);
	import pcmp_pkg::*;

	localparam int PER_CYC = `PCMP_PER_UNIT_NS / `PCMP_CLK_NS;

	pcmp_st_t s, n;
	logic [31:0] qpos, xpos, pos;
	logic en, fwd, u0, u1, d0, d1, ev0, ev1, evend, act, win;
	pcmp_mode_t mode;

	// Reached from below: earlier sample under, new one at or over
	function automatic logic cross_up(input logic [31:0] p,
		input logic [31:0] c, input logic [31:0] v);
		cross_up = ($signed(p) < $signed(v)) && ($signed(c) >= $signed(v));
	endfunction

	// Reached from above
	function automatic logic cross_dn(input logic [31:0] p,
		input logic [31:0] c, input logic [31:0] v);
		cross_dn = ($signed(p) > $signed(v)) && ($signed(c) <= $signed(v));
	endfunction

	pcmp_quad u_quad (
		.clock(clock),
		.rst(rst),
		.enc_a(enc_a),
		.enc_b(enc_b),
		.count(qpos)
	);

	pcmp_extrap #(.LOOP_CYC(LOOP_CYC)) u_extrap (
		.clock(clock),
		.rst(rst),
		.load(s.xload),
		.pos_in(s.xpos),
		.vel_in(s.xvel),
		.pos(xpos)
	);

	// Position source; switching it mid-run may look like a crossing
	assign pos = s.cfg[`PCMP_CFG_SRC] ? xpos : qpos;
	assign en = s.cfg[`PCMP_CFG_EN];
	assign mode = pcmp_mode_t'(s.cfg[`PCMP_CFG_MHI:`PCMP_CFG_MLO]);

	// Crossing detection against the previous sample
	assign u0 = cross_up(s.prev, pos, s.v0);
	assign u1 = cross_up(s.prev, pos, s.v1);
	assign d0 = cross_dn(s.prev, pos, s.v0);
	assign d1 = cross_dn(s.prev, pos, s.v1);

	// Single mode direction follows the sign of the increment
	assign fwd = ~s.inc[31];
	assign win = ($signed(pos) > $signed(s.v0)) &&
		($signed(pos) <= $signed(s.v1));

	// Match events per compare value
	always_comb
	begin
		ev0 = 1'b0;
		ev1 = 1'b0;
		evend = 1'b0;
		if (en)
		begin
			case (mode)
				PCMP_DUAL:
				begin
					ev0 = u0 | d0;
					ev1 = u1 | d1;
				end
				PCMP_SGL:
				begin
					ev0 = fwd ? u0 : d0;
				end
				PCMP_SGLE:
				begin
					ev0 = fwd ? u0 : d0;
					evend = fwd ? u1 : d1;
				end
				default:
				begin
					ev0 = 1'b0;
				end
			endcase
		end
	end

	// The end crossing stops the sequence, it does not fire the output
	assign act = ev0 | ev1;

	// Next state
	always_comb
	begin
		n = s;
		n.prev = pos;
		n.xload = 1'b0;
		n.rdata = 32'h0;

		// Compare value updates; zero increment leaves them fixed
		if (en && mode == PCMP_DUAL)
		begin
			if (u0)
				n.v1 = s.v1 + s.inc;
			if (u1)
				n.v0 = s.v0 + s.inc;
			if (d0)
				n.v1 = s.v1 - s.inc;
			if (d1)
				n.v0 = s.v0 - s.inc;
		end
		else if (ev0)
			n.v0 = s.v0 + s.inc;
		if (evend)
			n.cfg[`PCMP_CFG_EN] = 1'b0;

		// Output action
		if (!en)
		begin
			n.lvl = 1'b0;
			n.pcnt = '0;
		end
		else if (mode == PCMP_WIN)
		begin
			n.lvl = win;
			n.pcnt = '0;
		end
		else if (s.cfg[`PCMP_CFG_TOG])
		begin
			if (act)
				n.lvl = ~s.lvl;
			n.pcnt = '0;
		end
		else
		begin
			if (act)
				n.pcnt = 20'(32'(s.per) * PER_CYC);
			else if (s.pcnt != '0)
				n.pcnt = s.pcnt - 20'h1;
			n.lvl = (n.pcnt != '0);
		end

		// Register writes, except status flag clears, override same-cycle hardware updates
		if (wr)
		begin
			case (addr)
				`PCMP_A_CFG: n.cfg = wdata & `PCMP_CFG_WMASK;
				`PCMP_A_VAL0: n.v0 = wdata;
				`PCMP_A_VAL1: n.v1 = wdata;
				`PCMP_A_INC: n.inc = wdata;
				`PCMP_A_PER: n.per = wdata[`PCMP_PER_W-1:0];
				`PCMP_A_MASK: n.mask = wdata[`PCMP_ST_M1:`PCMP_ST_M0];
				`PCMP_A_XPOS: n.xpos = wdata;
				`PCMP_A_XVEL:
				begin
					// Velocity write starts the new loop period
					n.xvel = wdata;
					n.xload = 1'b1;
				end
				default: n.xload = 1'b0;
			endcase
		end

		// Sticky flags: a set in the clearing cycle wins
		n.flg = s.flg;
		if (wr && addr == `PCMP_A_STAT)
			n.flg = s.flg & ~wdata[`PCMP_ST_M1:`PCMP_ST_M0];
		n.flg = n.flg | {ev1 | evend, ev0};

		// Inversion applies to pin and status level alike
		n.pin = n.lvl ^ n.cfg[`PCMP_CFG_INV];
		n.irq = |(n.flg & n.mask);

		// Read data valid in the following cycle only
		if (rd)
		begin
			case (addr)
				`PCMP_A_CFG: n.rdata = s.cfg;
				`PCMP_A_STAT: n.rdata = {29'h0, s.flg, s.pin};
				`PCMP_A_VAL0: n.rdata = s.v0;
				`PCMP_A_VAL1: n.rdata = s.v1;
				`PCMP_A_INC: n.rdata = s.inc;
				`PCMP_A_PER: n.rdata = {12'h000, s.per};
				`PCMP_A_MASK: n.rdata = {29'h0, s.mask, 1'b0};
				`PCMP_A_XPOS: n.rdata = s.xpos;
				`PCMP_A_XVEL: n.rdata = s.xvel;
				`PCMP_A_POS: n.rdata = pos;
				default: n.rdata = 32'h0;
			endcase
		end
	end

	// State register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.cfg <= `PCMP_CFG_RST;
		end
		else
			s <= n;
	end

	assign rdata = s.rdata;
	assign cmp_out = s.pin;
	assign irq = s.irq;

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_dual_up;
		(en && mode == PCMP_DUAL && u0 && !u1 && !wr)
			|=> s.v1 == $past(s.v1) + $past(s.inc);
	endproperty
	a_dual_up: assert property (p_dual_up)
		else $error("dual up crossing did not advance value 1");

	property p_dual_dn;
		(en && mode == PCMP_DUAL && d0 && !d1 && !wr)
			|=> (s.v1 == $past(s.v1) - $past(s.inc)) && $stable(s.v0);
	endproperty
	a_dual_dn: assert property (p_dual_dn)
		else $error("dual down crossing handled wrongly");

	property p_dual_both;
		(en && mode == PCMP_DUAL && !s.cfg[`PCMP_CFG_TOG]
			&& (u1 || d1) && s.per != '0 && !wr) |=> s.lvl;
	endproperty
	a_dual_both: assert property (p_dual_both)
		else $error("crossing of value 1 gave no pulse");

	property p_single;
		(en && mode == PCMP_SGL && u0 && fwd && !wr)
			|=> s.v0 == $past(s.v0) + $past(s.inc);
	endproperty
	a_single: assert property (p_single)
		else $error("single mode did not advance value 0");

	// Reverse travel must leave value 0 where it is
	property p_one_dir;
		(en && (mode == PCMP_SGL || mode == PCMP_SGLE) && fwd && d0
			&& !wr) |=> s.v0 == $past(s.v0);
	endproperty
	a_one_dir: assert property (p_one_dir)
		else $error("single mode fired on reverse travel");

	property p_window;
		(en && mode == PCMP_WIN && !wr)
			|=> s.pin == ($past(win) ^ $past(s.cfg[`PCMP_CFG_INV]));
	endproperty
	a_window: assert property (p_window)
		else $error("window output wrong");

	property p_end;
		(evend && !wr) |=> !s.cfg[`PCMP_CFG_EN] ##1 !s.lvl;
	endproperty
	a_end: assert property (p_end)
		else $error("end crossing did not disable");

	sequence s_pulse_start;
		en && mode != PCMP_WIN && !s.cfg[`PCMP_CFG_TOG] && act
			&& s.per == 20'h5 && !wr;
	endsequence
	sequence s_pulse_body;
		s.lvl [*5] ##1 !s.lvl;
	endsequence
	property p_pulse;
		s_pulse_start ##1 !act [*5] |-> ##1 1'b1;
	endproperty
	property p_pulse_len;
		s_pulse_start ##1 (!act && en && !wr) [*5] |=> !s.lvl;
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("pulse longer than its period");
	property p_pulse_hi;
		s_pulse_start |=> s.lvl [*5];
	endproperty
	a_pulse_hi: assert property (p_pulse_hi)
		else $error("pulse shorter than its period");

	property p_toggle;
		(en && mode != PCMP_WIN && s.cfg[`PCMP_CFG_TOG] && act && !wr)
			|=> s.lvl != $past(s.lvl);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("toggle missed");

	property p_flag;
		ev0 |=> s.flg[0] && (irq == 1'b0 || s.mask != '0);
	endproperty
	a_flag: assert property (p_flag)
		else $error("match flag not set");

	// A one written with no event pending clears the flag
	property p_clear;
		(wr && addr == `PCMP_A_STAT && wdata[`PCMP_ST_M0] && !ev0)
			|=> !s.flg[0];
	endproperty
	a_clear: assert property (p_clear)
		else $error("match flag not cleared");

	property p_irq;
		##1 (irq == |($past(n.flg) & $past(n.mask)));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt level wrong");
endmodule
`default_nettype wire

// ---- pcmp_enc_model.sv ----
`default_nettype none
module pcmp_enc_model
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [31:0] target,
	output logic enc_a,
	output logic enc_b,
	output logic [31:0] pos
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] div_r;
	// One count every four clocks keeps edges far above the sync delay
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			div_r <= 2'h0;
			pos <= 32'h0;
		end
		else
		begin
			div_r <= div_r + 2'h1;
			if (div_r == 2'h3 && pos != target)
				pos <= ($signed(target) > $signed(pos)) ?
					pos + 32'h1 : pos - 32'h1;
		end
	end
	// Gray phase from the count, A leads B upward; linear, no wrap
	assign enc_a = pos[1] ^ pos[0];
	assign enc_b = pos[1];
endmodule
`default_nettype wire

// ---- position_compare_output_bench.sv ----
`include "pcmp_regs.svh"
`default_nettype none
module position_compare_output_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import pcmp_pkg::*;
	localparam int LC = 20;
	logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic enc_a, enc_b, cmp_out, irq;
	logic [7:0] addr = 8'h0, ra;
	logic [31:0] wdata = 32'h0, rdata, tgt = 32'h0, mpos, d, x, pp;
	logic [31:0] lf = 32'hc462;
	int errors = 0, n_tests = 0, run = 0, last = 0, npul = 0, k;
	always #5 clock = ~clock;
	pcmp_top #(.LOOP_CYC(LC)) dut (.clock(clock), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .enc_a(enc_a),
		.enc_b(enc_b), .cmp_out(cmp_out), .irq(irq));
	pcmp_enc_model enc (.clock(clock), .rst(rst), .target(tgt),
		.enc_a(enc_a), .enc_b(enc_b), .pos(mpos));
	// Pulse counter and width of the last pulse
	always @(posedge clock)
	begin
		if (cmp_out === 1'b1)
			run <= run + 1;
		else if (run != 0)
		begin
			last <= run;
			npul <= npul + 1;
			run <= 0;
		end
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c1_1db7 : 32'h0);
	endfunction
	function automatic logic win_exp(input logic [31:0] p, lo, hi);
		return $signed(p) > $signed(lo) && $signed(p) <= $signed(hi);
	endfunction
	function automatic logic [31:0] ext_exp(input logic [31:0] p,
		input logic [3:0] v);
		return p + 32'(LC) * {{28{v[3]}}, v};
	endfunction
	task report_and_stop;
		$display("tests=%0d errors=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Sampled just after the edge, once the pin has settled
	task cko(input logic e);
		#1 chk({31'h0, cmp_out}, {31'h0, e});
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] w);
		@(posedge clock);
		addr <= a;
		wdata <= w;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// Read data is taken only in the cycle after the strobe
	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// Move the encoder, then let sync and compare settle
	task goto(input logic [31:0] p);
		int i;
		tgt <= p;
		for (i = 0; i < 4000 && mpos !== p; i++)
			@(posedge clock);
		repeat (12) @(posedge clock);
	endtask
	// Watchdog far beyond the under one thousand cycles needed
	initial
	begin
		repeat (60000) @(posedge clock);
		errors++;
		report_and_stop;
	end
	initial
	begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		for (ra = 8'h0; ra <= 8'h30; ra += 8'h4)
			rchk(ra, 32'h0);
		wreg(`PCMP_A_CFG, 32'hfffe_ffe0);
		rchk(`PCMP_A_CFG, 32'h0);
		goto(32'd20);
		// Dual mode flanking the position, toggle output
		wreg(`PCMP_A_VAL0, 32'd10);
		wreg(`PCMP_A_VAL1, 32'd30);
		wreg(`PCMP_A_INC, 32'd40);
		wreg(`PCMP_A_MASK, 32'h6);
		wreg(`PCMP_A_CFG, 32'h5);
		goto(32'd31);
		rchk(`PCMP_A_VAL0, 32'd50);
		rchk(`PCMP_A_VAL1, 32'd30);
		cko(1'b1);
		rchk(`PCMP_A_STAT, 32'h5);
		chk({31'h0, irq}, 32'h1);
		wreg(`PCMP_A_MASK, 32'h0);
		rchk(`PCMP_A_STAT, 32'h5);
		chk({31'h0, irq}, 32'h0);
		wreg(`PCMP_A_MASK, 32'h6);
		wreg(`PCMP_A_STAT, 32'h6);
		rchk(`PCMP_A_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		goto(32'd29);
		rchk(`PCMP_A_VAL0, 32'd10);
		rchk(`PCMP_A_VAL1, 32'd30);
		cko(1'b0);
		// One fixed trigger point with a timed pulse
		wreg(`PCMP_A_INC, 32'd0);
		wreg(`PCMP_A_VAL0, 32'd25);
		wreg(`PCMP_A_VAL1, 32'd25);
		wreg(`PCMP_A_PER, 32'd5);
		wreg(`PCMP_A_CFG, 32'h1);
		k = npul;
		goto(32'd24);
		chk(32'(npul - k), 32'h1);
		chk(32'(last), 32'd5);
		goto(32'd26);
		chk(32'(npul - k), 32'h2);
		rchk(`PCMP_A_VAL0, 32'd25);
		wreg(`PCMP_A_CFG, 32'h3);
		repeat (3) @(posedge clock);
		cko(1'b1);
		// Single mode with positive increment counts upward only
		wreg(`PCMP_A_VAL0, 32'd30);
		wreg(`PCMP_A_INC, 32'd5);
		wreg(`PCMP_A_STAT, 32'h6);
		wreg(`PCMP_A_CFG, 32'hd);
		goto(32'd31);
		cko(1'b1);
		goto(32'd36);
		cko(1'b0);
		rchk(`PCMP_A_VAL0, 32'd40);
		rchk(`PCMP_A_STAT, 32'h2);
		wreg(`PCMP_A_VAL0, 32'd30);
		wreg(`PCMP_A_STAT, 32'h6);
		goto(32'd26);
		rchk(`PCMP_A_VAL0, 32'd30);
		rchk(`PCMP_A_STAT, 32'h0);
		// Window edges walked count by count
		wreg(`PCMP_A_VAL0, 32'd30);
		wreg(`PCMP_A_VAL1, 32'd33);
		wreg(`PCMP_A_CFG, 32'h11);
		for (pp = 32'd27; pp <= 32'd35; pp++)
		begin
			goto(pp);
			cko(win_exp(pp, 32'd30, 32'd33));
		end
		// End position turns the module off
		wreg(`PCMP_A_VAL0, 32'd40);
		wreg(`PCMP_A_VAL1, 32'd50);
		wreg(`PCMP_A_INC, 32'd5);
		wreg(`PCMP_A_STAT, 32'h6);
		wreg(`PCMP_A_CFG, 32'h1d);
		goto(32'd52);
		rchk(`PCMP_A_CFG, 32'h1c);
		rchk(`PCMP_A_STAT, 32'h6);
		cko(1'b0);
		rchk(`PCMP_A_POS, 32'd52);
		// Extrapolated source, random start and speed
		wreg(`PCMP_A_CFG, 32'h1_0000);
		repeat (3)
		begin
			lf = lfsr_next(lf);
			x = lf;
			lf = lfsr_next(lf);
			wreg(`PCMP_A_XPOS, x);
			wreg(`PCMP_A_XVEL, {{12{lf[3]}}, lf[3:0], 16'h0});
			repeat (30) @(posedge clock);
			rchk(`PCMP_A_POS, ext_exp(x, lf[3:0]));
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
